/* File: hri_handler_port.sv */
// Purpose: Handler port driving per-channel verdicts, summary and done pins.
// Assumes: Comparator verdicts arrive with a valid strobe per channel.
// Notes:   Outputs are open collector; an asserted pin is pulled low.
// Contract
// - One result pin per channel, 1 pass.
// - Channels eleven to twenty valid on large variant.
// - Summary pin shows combined verdict, 1 pass.
// - Done pin 0 measuring, 1 finished.
// - Trigger input starts a measurement.
// - Factory jumper setting: rising edge triggers.
// - Alternate jumper setting: falling edge triggers.
// - Outputs open collector, asserted means pulled low.
// - Done behaviour follows result grouping setting.
// - Single grouping flags each channel; all flags last.
`timescale 1ns/100ps
`default_nettype none
`include "hri_defines.svh"
module hri_handler_port #(
  parameter int CHAN_COUNT = `HRI_CHAN_MAX
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic                    trig_pin,
  input  wire logic                    edge_select_jumper_a,
  input  wire logic                    edge_select_jumper_b,
  input  wire logic                    group_single_channel,
  input  wire logic [4:0]              verdict_chan,
  input  wire logic                    verdict_valid,
  input  wire logic                    verdict_pass,
  output logic                         meas_start,
  output logic                         meas_busy,
  output hri_pkg::hri_pin_s [19:0]     chan_pin,
  output hri_pkg::hri_pin_s            summary_pin,
  output hri_pkg::hri_pin_s            done_pin
);
  import hri_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and next values.
  hri_state_e  state_q, state_d;
  logic        trig_q, trig_d;
  logic [19:0] result_q, result_d;
  logic [19:0] seen_q, seen_d;
  logic        done_q, done_d;
  logic        trig_edge;
  logic [19:0] chan_mask;
  logic [19:0] chan_oe;

  // Channels that exist on this variant.
  function automatic logic [19:0] enabled_mask(input int count);
    logic [19:0] m;
    m = 20'h00000;
    for (int i = 0; i < 20; i++) begin
      if (i < count) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  assign chan_mask = enabled_mask(CHAN_COUNT);

  // Edge select: both jumpers in the alternate position pick the falling edge.
  always_comb begin
    trig_d = trig_pin;
    if (edge_select_jumper_a && edge_select_jumper_b) begin
      trig_edge = trig_q && !trig_pin;
    end else begin
      trig_edge = !trig_q && trig_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencing and result capture.
  always_comb begin
    state_d  = state_q;
    result_d = result_q;
    seen_d   = seen_q;
    done_d   = done_q;
    case (state_q)
      HRI_IDLE, HRI_DONE: begin
        if (trig_edge) begin
          state_d = HRI_MEAS;
          seen_d  = 20'h00000;
          done_d  = 1'b0;
        end
      end
      HRI_MEAS: begin
        done_d = 1'b0;
        if (verdict_valid && verdict_chan < 5'(CHAN_COUNT)) begin
          result_d[verdict_chan] = verdict_pass;
          seen_d[verdict_chan]   = 1'b1;
          if (group_single_channel) begin
            done_d = 1'b1;
          end
        end
        if ((seen_d & chan_mask) == chan_mask) begin
          state_d = HRI_DONE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = HRI_IDLE;
      end
    endcase
  end

  // State registers; clock enable freezes everything.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q  <= HRI_IDLE;
      trig_q   <= `HRI_PIN_RST_VAL; // Idle level, so a released line is no edge.
      result_q <= `HRI_RES_RST_VAL;
      seen_q   <= 20'h00000;
      done_q   <= `HRI_DONE_RST_VAL;
    end else if (clk_en) begin
      state_q  <= state_d;
      trig_q   <= trig_d;
      result_q <= result_d;
      seen_q   <= seen_d;
      done_q   <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: logic 0 pulls the line low, logic 1 releases to the pull-up.
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      chan_pin[i].o  = 1'b0;
      chan_pin[i].oe = chan_mask[i] && !result_q[i];
    end
    summary_pin.o  = 1'b0;
    summary_pin.oe = |(chan_mask & ~result_q);
    done_pin.o     = 1'b0;
    done_pin.oe    = !done_q;
  end

  assign meas_start = clk_en && trig_edge && state_q != HRI_MEAS;
  assign meas_busy  = state_q == HRI_MEAS;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Each property watches pins or state that this module drives.

  // Per-channel pull-down enables gathered into one vector for the checks.
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      chan_oe[i] = chan_pin[i].oe;
    end
  end

  property p_done_low_measuring;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && meas_start) |=> !done_q;
  endproperty
  a_done_low_measuring: assert property (p_done_low_measuring) else $error("Done not cleared.");

  property p_stable_after_done;
    @(posedge ref_clk) disable iff (rst)
    (state_q == HRI_DONE && !trig_edge) |=> $stable(result_q);
  endproperty
  a_stable_after_done: assert property (p_stable_after_done) else $error("Results moved.");

  property p_summary_fail;
    @(posedge ref_clk) disable iff (rst)
    (|chan_oe) |-> summary_pin.oe;
  endproperty
  a_summary_fail: assert property (p_summary_fail) else $error("Summary missed fail.");

  property p_summary_pass;
    @(posedge ref_clk) disable iff (rst)
    !(|chan_oe) |-> !summary_pin.oe;
  endproperty
  a_summary_pass: assert property (p_summary_pass) else $error("Summary false fail.");

  property p_rise_start;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !(edge_select_jumper_a && edge_select_jumper_b) && !trig_q && trig_pin && state_q != HRI_MEAS)
      |=> state_q == HRI_MEAS;
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("Rising edge ignored.");

  property p_fall_start;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && edge_select_jumper_a && edge_select_jumper_b && trig_q && !trig_pin && state_q != HRI_MEAS)
      |=> state_q == HRI_MEAS;
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("Falling edge ignored.");

  property p_single_done;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && state_q == HRI_MEAS && group_single_channel && verdict_valid && verdict_chan < 5'(CHAN_COUNT))
      |=> !done_pin.oe;
  endproperty
  a_single_done: assert property (p_single_done) else $error("Per-channel done missing.");

  property p_upper_off;
    @(posedge ref_clk) disable iff (rst)
    (CHAN_COUNT <= `HRI_CHAN_SMALL) |-> !chan_pin[19].oe;
  endproperty
  a_upper_off: assert property (p_upper_off) else $error("Unused channel driven.");

  // A verdict lands on its own channel pin, a pass releasing it.
  property p_chan_verdict;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && meas_busy && verdict_valid && verdict_chan < 5'(CHAN_COUNT))
      |=> chan_oe[$past(verdict_chan)] == !$past(verdict_pass);
  endproperty
  a_chan_verdict: assert property (p_chan_verdict) else $error("Channel verdict not shown.");

  // Under all-channel grouping the done pin stays pulled low while measuring.
  property p_done_low_all;
    @(posedge ref_clk) disable iff (rst)
    (meas_busy && !group_single_channel && !$past(group_single_channel))
      |-> done_pin.oe;
  endproperty
  a_done_low_all: assert property (p_done_low_all) else $error("Done rose early.");
endmodule
`default_nettype wire

/* File: hri_defines.svh */
// Purpose: Constants for the handler result interface.
// Assumes: Included by bare name.
// Notes:   Definitions only.
`ifndef HRI_DEFINES_SVH
`define HRI_DEFINES_SVH
`define HRI_CHAN_MAX      20
`define HRI_CHAN_SMALL    10
`define HRI_MEAS_TIME_NS  1000
`define HRI_CLK_PERIOD_NS 100
`define HRI_MEAS_CYCLES   ((`HRI_MEAS_TIME_NS + `HRI_CLK_PERIOD_NS - 1) / `HRI_CLK_PERIOD_NS)
// Reset values; the trigger sample starts at the line's idle level.
`define HRI_PIN_RST_VAL   1'b1
`define HRI_DONE_RST_VAL  1'b1
`define HRI_RES_RST_VAL   20'h00000
`endif

/* File: hri_pkg.sv */
// Purpose: Types for the handler result interface.
// Assumes: Nothing.
// Notes:   Holds the state machine type and the pin carrier.
package hri_pkg;
  typedef enum logic [1:0] {
    HRI_IDLE = 2'b00,
    HRI_MEAS = 2'b01,
    HRI_DONE = 2'b10
  } hri_state_e;

  // One open-collector pin: level driven and its enable.
  typedef struct packed {
    logic o;
    logic oe;
  } hri_pin_s;
endpackage

/* File: hri_handler_model.sv */
// Purpose: Handler model that drives the trigger line.
// Assumes: The line idles high through its pull-up.
// Notes:   Each request pulls the line low for three cycles.
`timescale 1ns/100ps
`default_nettype none
module hri_handler_model (
  input  wire logic ref_clk,
  input  wire logic fire,
  output var  logic trig_pin
);
  logic [1:0] cnt_q;
  // Start idle, with the line released.
  initial begin
    cnt_q    = 2'h0;
    trig_pin = 1'b1;
  end
  // Assert by pulling low; the release gives the opposite edge.
  always @(negedge ref_clk) begin
    cnt_q    <= fire ? 2'h2 : cnt_q - 2'(cnt_q != 2'h0);
    trig_pin <= ~(fire | (cnt_q != 2'h0));
  end
endmodule
`default_nettype wire

/* File: hri_handler_port_test.sv */
// Purpose: Self-checking bench for the handler port.
// Assumes: Ten enabled channels; the upper ten must stay released.
// Notes:   A watcher compares the pins one cycle after each completion.
`timescale 1ns/100ps
`default_nettype none
module hri_handler_port_test;
  import hri_pkg::*;
  localparam int NCH = 10;
  logic            ref_clk = 1'b0;
  logic            rst, fire, trig_pin, jmp, grp, v_valid, v_pass, ce;
  logic            meas_start, meas_busy, prev_oe;
  logic [4:0]      v_chan;
  hri_pin_s [19:0] chan_pin;
  hri_pin_s        summary_pin, done_pin;
  logic [19:0]     exp_v;
  logic [20:0]     notes[$];
  int              errors, n_checks, m, n_starts;
  // Free-running clock at 10 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  hri_handler_port #(.CHAN_COUNT(NCH)) u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(ce), .trig_pin(trig_pin),
    .edge_select_jumper_a(jmp), .edge_select_jumper_b(jmp), .group_single_channel(grp), .verdict_chan(v_chan),
    .verdict_valid(v_valid), .verdict_pass(v_pass), .meas_start(meas_start), .meas_busy(meas_busy),
    .chan_pin(chan_pin), .summary_pin(summary_pin), .done_pin(done_pin));
  hri_handler_model u_hnd (.ref_clk(ref_clk), .fire(fire), .trig_pin(trig_pin));
  task check(input logic [20:0] g, input logic [20:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Pin view: per-channel pull-down enables and the summary enable on top.
  function automatic logic [20:0] pins();
    logic [20:0] r;
    for (int j = 0; j < 20; j++) r[j] = chan_pin[j].oe | chan_pin[j].o;
    r[20] = summary_pin.oe;
    return r;
  endfunction
  // Count accepted triggers, sampled before the edge acts on them.
  always @(posedge ref_clk) begin
    if (meas_start === 1'b1) n_starts <= n_starts + 1;
  end
  task test_done;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wait_busy(input logic lvl);
    int k;
    for (k = 0; k < 40 && meas_busy !== lvl; k++) @(negedge ref_clk);
    if (meas_busy !== lvl) begin
      errors++;
      test_done;
    end
  endtask
  // One triggered measurement, verdicts sent from the top channel down.
  task run_meas(input int md);
    int k;
    logic p;
    fire <= 1'b1;
    @(negedge ref_clk);
    fire <= 1'b0;
    wait_busy(1'b1);
    check({20'h0, done_pin.oe}, 21'h1);
    for (k = NCH - 1; k >= 0; k--) begin
      p = (md == 3) ? 1'b1 : 1'($urandom % 2);
      exp_v[k] = ~p;
      if (grp || k == 0) notes.push_back({|exp_v, exp_v});
      v_chan  <= 5'(k);
      v_pass  <= p;
      v_valid <= 1'b1;
      @(negedge ref_clk);
      v_valid <= 1'b0;
      repeat (3) @(negedge ref_clk);
    end
    wait_busy(1'b0);
    repeat (2) @(negedge ref_clk);
    $display("Test mode %0d finished", md);
  endtask
  // Watcher: a completion takes the oldest note and compares the pins.
  initial begin
    prev_oe = 1'b0;
    forever begin
      @(negedge ref_clk);
      if (prev_oe === 1'b1 && done_pin.oe === 1'b0) begin
        @(negedge ref_clk);
        check(pins(), notes.pop_front());
      end
      prev_oe = done_pin.oe;
    end
  end
  // Main sequence: each edge choice under each grouping.
  initial begin
    {rst, fire, jmp, grp, v_valid, v_pass, v_chan} = {4'h8, 7'h0};
    ce = 1'b1;
    n_starts = 0;
    exp_v = 20'h003FF;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'h19c8aec9));
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (m = 0; m < 4; m++) begin
      jmp = m[0];
      grp = m[1];
      run_meas(m);
    end
    // Frozen clock enable: a falling trigger edge must not start anything.
    ce = 1'b0;
    fire <= 1'b1;
    @(negedge ref_clk);
    fire <= 1'b0;
    repeat (8) @(negedge ref_clk);
    ce = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({19'h0, meas_busy, done_pin.oe}, 21'h0);
    $display("Test freeze finished");
    // Reset while idle: enabled channels show fail, done shows finished, no false start.
    jmp = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(pins(), {1'b1, 20'h003FF});
    check({19'h0, meas_busy, done_pin.oe}, 21'h0);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({19'h0, meas_busy, done_pin.oe}, 21'h0);
    $display("Test reset finished");
    exp_v = 20'h003FF;
    run_meas(4);
    check(21'(n_starts), 21'h5);
    check(21'(notes.size()), 21'h0);
    test_done;
  end
endmodule
`default_nettype wire
